// *** common/gauge_flags_pkg.sv ***
// Purpose: shared constants and carriers for the gauge status flag block
// Assumes: 20 MHz system clock, 8-bit register data, 7-bit register address
// Notes:   times are kept in their own units, and cycle counts are derived from them
package gauge_flags_pkg;
	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [6:0] PRIMARY_FLAGS_ADDR   = 7'h01;
	localparam logic [6:0] TEMP_GAUGE_ADDR      = 7'h02;
	localparam logic [6:0] SECONDARY_FLAGS_ADDR = 7'h06;
	localparam logic [7:0] RESERVED_READ        = 8'h00;
	localparam logic       PRIMARY_BIT2_VALUE   = 1'b1;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam longint CLK_HZ       = 20000000;
	localparam longint BLINK_HZ     = 4;
	localparam longint OVERLOAD_HOLD_MS = 500;
	localparam longint BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
	localparam longint OVERLOAD_HOLD_CYC = (CLK_HZ / 1000) * OVERLOAD_HOLD_MS;
	// ---------------------------------------------------------------
	// thresholds and counts
	// ---------------------------------------------------------------
	localparam int         FULL_RATIO_NUM  = 94;
	localparam int         FULL_RATIO_DEN  = 100;
	localparam logic [7:0] CHARGE_FLAG_COUNT = 8'h40;
	localparam logic [7:0] CHARGE_CNT_MAX    = 8'hff;
	localparam logic [1:0] SUSTAIN_UPDATES = 2'h2;
	localparam int         SELF_DIS_SHIFT  = 4;
	localparam int         FINAL_DROP_MV   = 25;
	localparam int         SAMPLE_FULL_MV  = 1200;
	localparam logic [7:0] FINAL_DROP_LSB  = 8'((FINAL_DROP_MV * 256) / SAMPLE_FULL_MV);
	localparam int         TEMP_LOW_C      = -30;
	localparam int         TEMP_HIGH_C     = 80;
	localparam int         TEMP_STEP_C     = 10;
	localparam logic [3:0] TEMP_CODE_LOW   = 4'h0;
	localparam logic [3:0] TEMP_CODE_HIGH  = 4'hc;
	localparam logic [3:0] GAUGE_MAX       = 4'hf;
	localparam logic [2:0] RATE_LOW        = 3'h0;
	localparam logic [2:0] RATE_MID        = 3'h1;
	localparam logic [2:0] RATE_HIGH       = 3'h2;
	// ---------------------------------------------------------------
	// flag carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic capacity_inaccurate_flag;
		logic valid_discharge_flag;
		logic first_empty_warning;
		logic final_empty_warning;
	} primary_state_t;
	typedef struct packed {
		logic [2:0] discharge_rate_class;
		logic       sense_activity_test_bit;
		logic       valid_charge_seen;
		logic       overload_flag;
	} secondary_state_t;
endpackage

// *** core/gauge_status_flag_logic.sv ***
// Purpose: status flags, temperature band and gauge level of a capacity gauge
// Assumes: event strobes and levels come from logic on clk_sys; reads take one cycle
// Notes:   the serial link presents reg_addr and takes reg_rd_data a cycle later
//
// Notes on behaviour
// - inaccurate flag: set at 64 charges, reset; clear on update
// - valid discharge set on first discharge near full
// - self-discharge over 6.25% clears valid discharge
// - charge across two capacity updates clears valid discharge
// - first warning below zero degrees clears valid discharge
// - first warning under threshold, no overload, latched
// - first segment blinks at 4Hz after first warning
// - final warning 25mV lower, under 2C, latched
// - final warning switches every segment off
// - upper temperature nibble is ten-degree band code
// - lower nibble is gauge level in sixteenths
// - short discharge count loads 0.94 of full capacity
// - rate class bits 6-4: 000, 001, 010
// - valid charge flag set; cleared after discharge from full
// - overload while above 2C, released 0.5 s later
// - overload suspends voltage sampling for empty detection
// - undefined register addresses are reserved
// - charge counts only above qualification threshold
// - counter reaching 64 raises inaccurate flag
`timescale 1ns/10ps
`default_nettype none
module gauge_status_flag_logic #(
	parameter int     CAP_W          = 16,
	parameter longint BLINK_HALF_CYC = gauge_flags_pkg::BLINK_HALF_CYC,
	parameter longint OVERLOAD_HOLD_CYC = gauge_flags_pkg::OVERLOAD_HOLD_CYC
) (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic              cmd_reset,
	input  wire logic              charge_stb,
	input  wire logic              sense_above_qual,
	input  wire logic              discharge_stb,
	input  wire logic              self_discharge_stb,
	input  wire logic              capacity_update_stb,
	input  wire logic              full_capacity_update_stb,
	input  wire logic              voltage_sample_stb,
	input  wire logic [7:0]        cell_voltage_sample,
	input  wire logic [7:0]        empty_threshold_setting,
	input  wire logic signed [7:0] temperature_c,
	input  wire logic              rate_at_least_half_c,
	input  wire logic              rate_above_2c,
	input  wire logic              sense_activity,
	input  wire logic              display_enable,
	input  wire logic [CAP_W-1:0]  nominal_capacity_count,
	input  wire logic [CAP_W-1:0]  learned_full_capacity,
	input  wire logic [CAP_W-1:0]  measured_discharge_count,
	input  wire logic [CAP_W-1:0]  compensated_capacity,
	input  wire logic [6:0]        reg_addr,
	output logic [7:0]             reg_rd_data_reg,
	output logic                   first_led_segment_blank_reg,
	output logic                   segments_off_reg,
	output logic                   full_capacity_load_reg,
	output logic [CAP_W-1:0]       full_capacity_value_reg
);
	localparam int PW = CAP_W + 7;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	gauge_flags_pkg::primary_state_t   prim_reg, prim_next;
	gauge_flags_pkg::secondary_state_t sec_reg, sec_next;
	logic [7:0]       charge_cnt_reg, charge_cnt_next;
	logic             charge_hold_reg, charge_hold_next;
	logic             full_armed_reg, full_armed_next;
	logic             at_full_reg, at_full_next;
	logic [CAP_W-1:0] discharge_ref_reg, discharge_ref_next;
	logic [1:0]       sustain_reg, sustain_next;
	logic [3:0]       temp_code_reg, temp_code_next;
	logic [3:0]       gauge_reg, gauge_next;
	logic [23:0]      blink_cnt_reg, blink_cnt_next;
	logic [23:0]      hold_cnt_reg, hold_cnt_next;
	logic             blink_reg, blink_next;
	logic [7:0]       rd_next;
	logic             load_next;
	logic [CAP_W-1:0] load_val_next;

	logic             charge_ev;
	logic             near_full;
	logic [PW-1:0]    full_scaled;
	logic [CAP_W+3:0] gauge_q;
	logic [7:0]       final_thr;
	logic             empty_sample;
	int               band;

	// ---------------------------------------------------------------
	// next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		prim_next       = prim_reg;
		sec_next        = sec_reg;
		charge_cnt_next    = charge_cnt_reg;
		charge_hold_next   = charge_hold_reg;
		discharge_ref_next = discharge_ref_reg;
		sustain_next    = sustain_reg;
		blink_cnt_next  = blink_cnt_reg;
		blink_next      = blink_reg;
		hold_cnt_next   = hold_cnt_reg;
		load_next       = 1'b0;
		load_val_next   = full_capacity_value_reg;
		band            = 0;
		charge_ev  = charge_stb && sense_above_qual;
		full_scaled = PW'(learned_full_capacity) * PW'(gauge_flags_pkg::FULL_RATIO_NUM);
		near_full   = PW'(nominal_capacity_count) * PW'(gauge_flags_pkg::FULL_RATIO_DEN)
			>= full_scaled;
		full_armed_next = near_full ? 1'b1 : (discharge_stb ? 1'b0 : full_armed_reg);
		at_full_next    = at_full_reg;
		if (nominal_capacity_count == learned_full_capacity) begin
			at_full_next = 1'b1;
		end

		// full-capacity update: counter and flags restart
		if (full_capacity_update_stb) begin
			charge_cnt_next                = '0;
			prim_next.capacity_inaccurate_flag = 1'b0;
			prim_next.valid_discharge_flag     = 1'b0;
			load_next                      = 1'b1;
			if (PW'(measured_discharge_count) * PW'(gauge_flags_pkg::FULL_RATIO_DEN)
				< full_scaled) begin
				load_val_next = CAP_W'(full_scaled / PW'(gauge_flags_pkg::FULL_RATIO_DEN));
			end else begin
				load_val_next = measured_discharge_count;
			end
		end

		// trickle charge near full bumps the counter only once
		if (!near_full) begin
			charge_hold_next = 1'b0;
		end
		if (charge_ev && !(near_full && charge_hold_reg)
			&& charge_cnt_reg != gauge_flags_pkg::CHARGE_CNT_MAX) begin
			charge_cnt_next  = charge_cnt_reg + 8'h01;
			charge_hold_next = near_full;
			if (charge_cnt_next == gauge_flags_pkg::CHARGE_FLAG_COUNT) begin
				prim_next.capacity_inaccurate_flag = 1'b1;
			end
		end

		// valid discharge clears
		if (self_discharge_stb && prim_reg.valid_discharge_flag
			&& discharge_ref_reg > nominal_capacity_count
			&& (discharge_ref_reg - nominal_capacity_count)
			> (discharge_ref_reg >> gauge_flags_pkg::SELF_DIS_SHIFT)) begin
			prim_next.valid_discharge_flag = 1'b0;
		end
		if (!sense_above_qual) begin
			sustain_next = '0;
		end else if (capacity_update_stb && sustain_reg != gauge_flags_pkg::SUSTAIN_UPDATES) begin
			sustain_next = sustain_reg + 2'h1;
		end
		if (sustain_next == gauge_flags_pkg::SUSTAIN_UPDATES) begin
			prim_next.valid_discharge_flag = 1'b0;
		end

		// empty warnings: a charge clears, a sample sets, so a set wins
		if (charge_ev) begin
			prim_next.first_empty_warning = 1'b0;
			prim_next.final_empty_warning = 1'b0;
			sec_next.valid_charge_seen    = 1'b1;
		end
		final_thr    = (empty_threshold_setting > gauge_flags_pkg::FINAL_DROP_LSB)
			? empty_threshold_setting - gauge_flags_pkg::FINAL_DROP_LSB : 8'h00;
		empty_sample = voltage_sample_stb && !sec_reg.overload_flag;
		if (empty_sample && cell_voltage_sample < empty_threshold_setting) begin
			prim_next.first_empty_warning = 1'b1;
			if (!prim_reg.first_empty_warning && temperature_c < 8'sh00) begin
				prim_next.valid_discharge_flag = 1'b0;
			end
		end
		if (empty_sample && cell_voltage_sample < final_thr) begin
			prim_next.final_empty_warning = 1'b1;
		end

		// valid discharge set; discharge from full drops the charge flag
		if (discharge_stb) begin
			if (full_armed_reg && !prim_reg.valid_discharge_flag) begin
				prim_next.valid_discharge_flag = 1'b1;
				discharge_ref_next             = nominal_capacity_count;
			end
			if (at_full_reg && !charge_ev) begin
				sec_next.valid_charge_seen = 1'b0;
				at_full_next               = 1'b0;
			end
		end

		// reset by command behaves like a power-on reset of the primary flags; secondary flags keep their values
		if (cmd_reset) begin
			prim_next                          = '0;
			prim_next.capacity_inaccurate_flag = 1'b1;
		end

		// rate class and overload hold-off
		if (rate_above_2c) begin
			sec_next.discharge_rate_class = gauge_flags_pkg::RATE_HIGH;
		end else if (rate_at_least_half_c) begin
			sec_next.discharge_rate_class = gauge_flags_pkg::RATE_MID;
		end else begin
			sec_next.discharge_rate_class = gauge_flags_pkg::RATE_LOW;
		end
		sec_next.sense_activity_test_bit = sense_activity;
		if (rate_above_2c) begin
			sec_next.overload_flag = 1'b1;
			hold_cnt_next          = '0;
		end else if (sec_reg.overload_flag) begin
			if (hold_cnt_reg == 24'(OVERLOAD_HOLD_CYC - 1)) begin
				sec_next.overload_flag = 1'b0;
				hold_cnt_next          = '0;
			end else begin
				hold_cnt_next = hold_cnt_reg + 24'h1;
			end
		end

		// low-battery blink, restarted whenever it is not wanted
		if (prim_reg.first_empty_warning && display_enable) begin
			if (blink_cnt_reg == 24'(BLINK_HALF_CYC - 1)) begin
				blink_cnt_next = '0;
				blink_next     = !blink_reg;
			end else begin
				blink_cnt_next = blink_cnt_reg + 24'h1;
			end
		end else begin
			blink_cnt_next = '0;
			blink_next     = 1'b0;
		end

		// temperature band and gauge level
		if (temperature_c < 8'(gauge_flags_pkg::TEMP_LOW_C)) begin
			temp_code_next = gauge_flags_pkg::TEMP_CODE_LOW;
		end else if (temperature_c >= 8'(gauge_flags_pkg::TEMP_HIGH_C)) begin
			temp_code_next = gauge_flags_pkg::TEMP_CODE_HIGH;
		end else begin
			band           = (int'(temperature_c) - gauge_flags_pkg::TEMP_LOW_C)
				/ gauge_flags_pkg::TEMP_STEP_C + 1;
			temp_code_next = 4'(band);
		end
		// a zero full capacity would divide by zero, so it reads as empty
		if (learned_full_capacity == '0) begin
			gauge_q = '0;
		end else begin
			gauge_q = ({compensated_capacity, 4'h0} / (CAP_W+4)'(learned_full_capacity));
		end
		gauge_next = (gauge_q > (CAP_W+4)'(gauge_flags_pkg::GAUGE_MAX))
			? gauge_flags_pkg::GAUGE_MAX : gauge_q[3:0];

		// register read port
		case (reg_addr)
			gauge_flags_pkg::PRIMARY_FLAGS_ADDR:
				rd_next = {3'h0, prim_reg.capacity_inaccurate_flag,
					prim_reg.valid_discharge_flag, gauge_flags_pkg::PRIMARY_BIT2_VALUE,
					prim_reg.first_empty_warning, prim_reg.final_empty_warning};
			gauge_flags_pkg::TEMP_GAUGE_ADDR:
				rd_next = {temp_code_reg, gauge_reg};
			gauge_flags_pkg::SECONDARY_FLAGS_ADDR:
				rd_next = {1'b0, sec_reg.discharge_rate_class,
					sec_reg.sense_activity_test_bit, sec_reg.valid_charge_seen,
					1'b0, sec_reg.overload_flag};
			default:
				rd_next = gauge_flags_pkg::RESERVED_READ;
		endcase
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prim_reg                    <= '{capacity_inaccurate_flag: 1'b1, default: 1'b0};
			sec_reg                     <= '0;
			charge_cnt_reg              <= '0;
			charge_hold_reg             <= 1'b0;
			full_armed_reg              <= 1'b0;
			at_full_reg                 <= 1'b0;
			discharge_ref_reg           <= '0;
			sustain_reg                 <= '0;
			temp_code_reg               <= '0;
			gauge_reg                   <= '0;
			blink_cnt_reg               <= '0;
			hold_cnt_reg                <= '0;
			blink_reg                   <= 1'b0;
			reg_rd_data_reg             <= '0;
			first_led_segment_blank_reg <= 1'b0;
			segments_off_reg            <= 1'b0;
			full_capacity_load_reg      <= 1'b0;
			full_capacity_value_reg     <= '0;
		end else begin
			prim_reg                    <= prim_next;
			sec_reg                     <= sec_next;
			charge_cnt_reg              <= charge_cnt_next;
			charge_hold_reg             <= charge_hold_next;
			full_armed_reg              <= full_armed_next;
			at_full_reg                 <= at_full_next;
			discharge_ref_reg           <= discharge_ref_next;
			sustain_reg                 <= sustain_next;
			temp_code_reg               <= temp_code_next;
			gauge_reg                   <= gauge_next;
			blink_cnt_reg               <= blink_cnt_next;
			hold_cnt_reg                <= hold_cnt_next;
			blink_reg                   <= blink_next;
			reg_rd_data_reg             <= rd_next;
			first_led_segment_blank_reg <= blink_next;
			segments_off_reg            <= prim_next.final_empty_warning;
			full_capacity_load_reg      <= load_next;
			full_capacity_value_reg     <= load_val_next;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_inaccurate_on_count: assert property (@(posedge clk_sys) disable iff (rst)
		(charge_cnt_reg != gauge_flags_pkg::CHARGE_FLAG_COUNT) ##1
		(charge_cnt_reg == gauge_flags_pkg::CHARGE_FLAG_COUNT)
		|-> prim_reg.capacity_inaccurate_flag)
		else $error("inaccurate flag missing at count 64");
	a_update_clears: assert property (@(posedge clk_sys) disable iff (rst)
		full_capacity_update_stb && !charge_ev && !cmd_reset
		|=> !prim_reg.capacity_inaccurate_flag && charge_cnt_reg == 8'h00)
		else $error("capacity update did not clear counter");
	a_edv_charge_clear: assert property (@(posedge clk_sys) disable iff (rst)
		charge_ev && !voltage_sample_stb |=> !prim_reg.first_empty_warning
		&& !prim_reg.final_empty_warning)
		else $error("valid charge did not clear empty warnings");
	a_overload_no_sample: assert property (@(posedge clk_sys) disable iff (rst)
		sec_reg.overload_flag && !prim_reg.first_empty_warning && !cmd_reset
		|=> !prim_reg.first_empty_warning)
		else $error("empty warning set during overload");
	a_overload_follows: assert property (@(posedge clk_sys) disable iff (rst)
		rate_above_2c |=> sec_reg.overload_flag
		&& sec_reg.discharge_rate_class == gauge_flags_pkg::RATE_HIGH)
		else $error("overload not flagged above 2C");
	a_segs_off: assert property (@(posedge clk_sys) disable iff (rst)
		prim_reg.final_empty_warning |-> segments_off_reg)
		else $error("segments on during final warning");
	a_blink_idle: assert property (@(posedge clk_sys) disable iff (rst)
		!prim_reg.first_empty_warning ##1 !prim_reg.first_empty_warning
		|-> !first_led_segment_blank_reg)
		else $error("segment blinks without warning");
	a_charge_flag_sets: assert property (@(posedge clk_sys) disable iff (rst)
		charge_ev |=> sec_reg.valid_charge_seen)
		else $error("valid charge flag not set");
	a_short_load: assert property (@(posedge clk_sys) disable iff (rst)
		full_capacity_update_stb |=> full_capacity_load_reg
		&& (full_capacity_value_reg == $past(measured_discharge_count)
		|| PW'(full_capacity_value_reg) * PW'(gauge_flags_pkg::FULL_RATIO_DEN)
		<= $past(full_scaled)))
		else $error("full capacity load value wrong");
	a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (rst)
		reg_addr > gauge_flags_pkg::SECONDARY_FLAGS_ADDR |=> reg_rd_data_reg == 8'h00)
		else $error("unmapped address read non-zero");
endmodule
`default_nettype wire

// *** verif/gauge_host_model.sv ***
// Purpose: host side of the register read port, one read at a time
// Assumes: read data appears one clock after the address is presented
// Notes:   idles on an unmapped address so stale data is never mistaken
`timescale 1ns/10ps
`default_nettype none
module gauge_host_model (
	input  wire logic       clk_sys,
	input  wire logic [7:0] rd_data,
	output var logic  [6:0] reg_addr
);
	initial reg_addr = 7'h7f;
	// no write path exists, so reserved secondary bits are never written
	task automatic read(input logic [6:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		@(negedge clk_sys);
		d = rd_data;
		// the test bit wanders, so it is dropped
		if (a === gauge_flags_pkg::SECONDARY_FLAGS_ADDR) d[3] = 1'b0;
		reg_addr = 7'h7f;
	endtask
endmodule
`default_nettype wire

// *** verif/gauge_status_flag_logic_bench.sv ***
// Purpose: self-checking bench for the gauge status flag block
// Assumes: short blink and overload hold counts for simulation
// Notes:   expected values come from the flag rules, not the outputs
`timescale 1ns/10ps
`default_nettype none
module gauge_status_flag_logic_bench;
	logic clk_sys, rst, sns, disp, half_c, above_2c;
	logic [6:0] stb;
	logic [7:0] vs, thr_set, rd;
	logic signed [7:0] temp;
	logic [15:0] nom, full, meas, comp_cap, val;
	logic [6:0] addr;
	logic blank, segoff, load;
	int error_cnt, n_tests, cyc;
	localparam logic [6:0] P = 7'h01, T = 7'h02, S = 7'h06;

	gauge_status_flag_logic #(.CAP_W(16), .BLINK_HALF_CYC(4), .OVERLOAD_HOLD_CYC(8)) dut (
		.clk_sys(clk_sys), .rst(rst), .cmd_reset(stb[6]), .charge_stb(stb[0]),
		.sense_above_qual(sns), .discharge_stb(stb[1]), .self_discharge_stb(stb[2]),
		.capacity_update_stb(stb[3]), .full_capacity_update_stb(stb[4]),
		.voltage_sample_stb(stb[5]), .cell_voltage_sample(vs),
		.empty_threshold_setting(thr_set), .temperature_c(temp),
		.rate_at_least_half_c(half_c), .rate_above_2c(above_2c),
		.sense_activity(1'b1), .display_enable(disp),
		.nominal_capacity_count(nom), .learned_full_capacity(full),
		.measured_discharge_count(meas), .compensated_capacity(comp_cap),
		.reg_addr(addr), .reg_rd_data_reg(rd), .first_led_segment_blank_reg(blank),
		.segments_off_reg(segoff), .full_capacity_load_reg(load),
		.full_capacity_value_reg(val));
	gauge_host_model host (.clk_sys(clk_sys), .rd_data(rd), .reg_addr(addr));

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic print_verdict();
		$display("tests %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end

	task automatic ck(string nm, logic [15:0] e, logic [15:0] s);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic chk(logic [6:0] a, logic [7:0] m, logic [7:0] e);
		logic [7:0] d;
		host.read(a, d);
		ck($sformatf("reg %h", a), 16'(e & m), 16'(d & m));
	endtask
	task automatic pulse(int i);
		@(negedge clk_sys);
		stb[i] = 1'b1;
		@(negedge clk_sys);
		stb[i] = 1'b0;
	endtask
	task automatic sample(logic [7:0] v);
		vs = v;
		pulse(5);
	endtask

	task automatic t_reset();
		chk(P, 8'hff, 8'h14);
		chk(S, 8'hff, 8'h00);
		chk(7'h03, 8'hff, 8'h00);
		chk(7'h7f, 8'hff, 8'h00);
		ck("segments", 16'h0, {15'h0, segoff});
		$display("reset test done");
	endtask

	task automatic t_ci();
		meas = 16'd1000;
		pulse(4);
		ck("load", 16'h1, {15'h0, load});
		ck("value", 16'd1000, val);
		chk(P, 8'h10, 8'h00);
		ck("load", 16'h0, {15'h0, load});
		pulse(0);
		chk(S, 8'h04, 8'h00);
		sns = 1'b1;
		repeat (63) pulse(0);
		chk(P, 8'h10, 8'h00);
		pulse(0);
		sns = 1'b0;
		chk(P, 8'h10, 8'h10);
		chk(S, 8'h04, 8'h04);
		$display("charge count test done");
	endtask

	task automatic t_vdq();
		nom = 16'd1000;
		pulse(1);
		chk(P, 8'h08, 8'h08);
		chk(S, 8'h04, 8'h00);
		nom = 16'd938;
		pulse(2);
		chk(P, 8'h08, 8'h08);
		nom = 16'd937;
		pulse(2);
		chk(P, 8'h08, 8'h00);
		nom = 16'd1000;
		pulse(1);
		sns = 1'b1;
		pulse(3);
		chk(P, 8'h08, 8'h08);
		pulse(3);
		sns = 1'b0;
		chk(P, 8'h08, 8'h00);
		pulse(1);
		temp = -8'sd5;
		sample(8'h00);
		chk(P, 8'h0b, 8'h03);
		temp = 8'sd25;
		sns = 1'b1;
		pulse(0);
		sns = 1'b0;
		pulse(1);
		meas = 16'd500;
		pulse(4);
		ck("value", 16'd940, val);
		chk(P, 8'h18, 8'h00);
		$display("valid discharge test done");
	endtask

	task automatic t_empty();
		logic b;
		int n;
		above_2c = 1'b1;
		sample(8'h00);
		chk(P, 8'h03, 8'h00);
		chk(S, 8'h71, 8'h21);
		above_2c = 1'b0;
		chk(S, 8'h01, 8'h01);
		repeat (8) @(negedge clk_sys);
		chk(S, 8'h01, 8'h00);
		sample(8'ha2);
		chk(P, 8'h03, 8'h00);
		sample(8'ha1);
		chk(P, 8'h03, 8'h02);
		b = blank;
		n = 0;
		while (blank === b && n < 6) begin
			@(negedge clk_sys);
			n++;
		end
		b = blank;
		ck("blink edge", 16'h1, 16'(n < 6));
		repeat (3) @(negedge clk_sys);
		ck("blink hold", {15'h0, b}, {15'h0, blank});
		repeat (2) @(negedge clk_sys);
		ck("blink toggle", {15'h0, ~b}, {15'h0, blank});
		sample(8'h9d);
		chk(P, 8'h03, 8'h02);
		ck("segments", 16'h0, {15'h0, segoff});
		sample(8'h9c);
		chk(P, 8'h03, 8'h03);
		ck("segments", 16'h1, {15'h0, segoff});
		sns = 1'b1;
		pulse(0);
		sns = 1'b0;
		chk(P, 8'h03, 8'h00);
		ck("segments", 16'h0, {15'h0, segoff});
		$display("empty warning test done");
	endtask

	task automatic t_rates();
		half_c = 1'b0;
		chk(S, 8'h70, 8'h00);
		half_c = 1'b1;
		chk(S, 8'h70, 8'h10);
		half_c = 1'b0;
		$display("rate class test done");
	endtask

	task automatic t_temp();
		int tc[6] = '{-31, -29, 0, 79, 80, 100};
		logic [3:0] code[6] = '{4'h0, 4'h1, 4'h4, 4'hb, 4'hc, 4'hc};
		for (int i = 0; i < 6; i++) begin
			temp = 8'(tc[i]);
			chk(T, 8'hf0, {code[i], 4'h0});
		end
		temp = 8'sd25;
		comp_cap = 16'd500;
		chk(T, 8'h0f, 8'h08);
		comp_cap = 16'd1000;
		chk(T, 8'h0f, 8'h0f);
		$display("temperature test done");
	endtask

	task automatic t_cmd_reset();
		pulse(6);
		chk(P, 8'h1b, 8'h10);
		$display("command reset test done");
	endtask

	initial begin
		{sns, disp, half_c, above_2c, stb} = '0;
		{vs, nom, meas, comp_cap} = '0;
		thr_set = 8'ha2;
		temp = 8'sd25;
		full = 16'd1000;
		disp = 1'b1;
		rst = 1'b1;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'b0;
		t_reset();
		t_ci();
		t_vdq();
		t_empty();
		t_rates();
		t_temp();
		t_cmd_reset();
		print_verdict();
	end
endmodule
`default_nettype wire
